// ### core/eecfg_defines.svh
// Purpose: constants of the power-on configuration loader
// Assumes: 16-bit configuration words, byte-wide switch registers
// Notes: definitions only
`ifndef EECFG_DEFINES_SVH
`define EECFG_DEFINES_SVH

// value that enables a two-bit enable field
`define EECFG_EN_VAL 2'h1

// configuration word numbers
`define EECFG_W_MAC0 6'h00
`define EECFG_W_MAC1 6'h01
`define EECFG_W_MAC2 6'h02
`define EECFG_W_AUTOLD 6'h03
`define EECFG_W_VID 6'h04
`define EECFG_W_PID 6'h05
`define EECFG_W_PINCTL 6'h06
`define EECFG_W_PHYCTL 6'h07
`define EECFG_W_GRPCTL 6'h10
`define EECFG_W_LAST 6'h2F

// auto-load control word field positions (low bit of each field)
`define EECFG_AL_ID 0
`define EECFG_AL_PIN 2
`define EECFG_AL_PHY 14

// group control word field positions
`define EECFG_G_SW 0
`define EECFG_G_PORT 2
`define EECFG_G_TAG 4
`define EECFG_G_VPRI 6
`define EECFG_G_VGRP 8
`define EECFG_G_TOS 10

// pin control word bits
`define EECFG_PIN_CS 0
`define EECFG_PIN_RD 1
`define EECFG_PIN_WR 2
`define EECFG_PIN_IRQLOW 3
`define EECFG_PIN_IRQOC 4
`define EECFG_PIN_W 5

// phy control word bits
`define EECFG_PHY_MDIX1 14
`define EECFG_PHY_MDIX0 15

// switch register offsets
`define EECFG_R_SW52 8'h52
`define EECFG_R_SW53 8'h53
`define EECFG_R_SW58 8'h58
`define EECFG_R_SW59 8'h59
`define EECFG_R_PC61 8'h61
`define EECFG_R_PC66 8'h66
`define EECFG_R_PC67 8'h67
`define EECFG_R_PC6D 8'h6D
`define EECFG_R_TAGL 8'h6E
`define EECFG_R_TAGH 8'h6F
`define EECFG_R_VPRL 8'hD0
`define EECFG_R_VPRH 8'hD1
`define EECFG_R_VGRP_HI 4'hB
`define EECFG_R_TOS_HI 4'hC

// port field of the register address
`define EECFG_PORT0 2'h0
`define EECFG_PORT1 2'h1
`define EECFG_PAGE_LD 2'h2
`define EECFG_PORT3 2'h3

// loader page offsets
`define EECFG_L_MAC0 8'h00
`define EECFG_L_VIDL 8'h06
`define EECFG_L_VIDH 8'h07
`define EECFG_L_PIDL 8'h08
`define EECFG_L_PIDH 8'h09
`define EECFG_L_PIN 8'h0A
`define EECFG_L_PHY 8'h0B
`define EECFG_L_STAT 8'h0C
`define EECFG_L_CTRL 8'h0D

// reset values
`define EECFG_CFG_RST 8'h00
`define EECFG_PIN_RST 5'h00
`define EECFG_MDIX_RST 1'b1
`define EECFG_NBYTES 56

`endif

// ### core/eecfg_pkg.sv
// Purpose: types of the power-on configuration loader
// Assumes: nothing beyond the defines header
// Notes: constants live in eecfg_defines.svh
package eecfg_pkg;
  // loader sequencer states
  typedef enum logic [1:0] {S_FETCH, S_HIGH, S_DONE} eecfg_state_t;
endpackage

// ### core/eecfg_pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter for one pin
// Assumes: pin is asynchronous to i_clk
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ps
module eecfg_pin_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_pin,
  output logic o_level
);
  logic meta_r; // first stage, read only by the second
  logic s2_r;
  logic s3_r;

  // shift chain
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      meta_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end
    else if (i_ce)
    begin
      meta_r <= i_pin;
      s2_r <= meta_r;
      s3_r <= s2_r;
    end
  end

  // accept a level once two stages agree
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_level <= RST_VAL;
    else if (i_ce && (s2_r == s3_r))
      o_level <= s3_r;
  end
endmodule

// ### core/eecfg_cfg_ram.sv
// Purpose: byte store of the switch configuration registers
// Assumes: one write port, combinational read
// Notes: every byte returns to its default under reset
`timescale 1ns/1ps
`include "eecfg_defines.svh"
module eecfg_cfg_ram #(
  parameter int NBYTES = `EECFG_NBYTES,
  parameter int IW = 6
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_we,
  input wire logic [IW-1:0] i_widx,
  input wire logic [7:0] i_wdata,
  input wire logic [IW-1:0] i_ridx,
  output logic [7:0] o_rdata
);
  logic [7:0] mem_r [NBYTES]; // configuration bytes

  generate
    if (NBYTES > (1 << IW))
    begin : g_chk
      $error("eecfg_cfg_ram: index too narrow for NBYTES");
    end
  endgenerate

  // write and reset to defaults
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      for (int i = 0; i < NBYTES; i++)
        mem_r[i] <= `EECFG_CFG_RST;
    end
    else if (i_ce && i_we && (int'(i_widx) < NBYTES))
      mem_r[i_widx] <= i_wdata;
  end

  // read, out of range gives zero
  always_comb
  begin
    if (int'(i_ridx) < NBYTES)
      o_rdata = mem_r[i_ridx];
    else
      o_rdata = 8'h00;
  end
endmodule

// ### core/eecfg_loader.sv
// Purpose: power-on loader copying a configuration word image into switch registers
// Assumes: word source answers each request with a one-cycle valid; same clock
// Notes: register address is {port[1:0], offset[7:0]}; port field 2 is the loader page
`timescale 1ns/1ps
`include "eecfg_defines.svh"
module eecfg_loader #(
  parameter logic [15:0] VENDOR_ID_DEF = 16'h1234, // arbitrary value
  parameter logic [15:0] PRODUCT_ID_DEF = 16'h5678, // arbitrary value
  parameter int EE_AW = 6
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // word source
  output logic o_ee_req,
  output logic [EE_AW-1:0] o_ee_addr,
  input wire logic i_ee_valid,
  input wire logic [15:0] i_ee_data,
  // register port
  input wire logic [9:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // processor pins
  input wire logic i_cs_pin,
  input wire logic i_read_strobe_in,
  input wire logic i_write_strobe_in,
  output logic o_cs_act,
  output logic o_rd_act,
  output logic o_wr_act,
  input wire logic i_irq_req,
  output logic o_irq_out,
  output logic o_irq_oe,
  // captured configuration
  output logic [47:0] o_mac_addr,
  output logic [15:0] o_vendor_id,
  output logic [15:0] o_product_id,
  output logic o_mdix_p0,
  output logic o_mdix_p1,
  output logic o_load_done
);
  eecfg_pkg::eecfg_state_t state_r; // sequencer state
  logic [5:0] word_r; // word being fetched
  logic [15:0] autold_r; // word 3 copy
  logic [15:0] grpctl_r; // word 16 copy
  logic [4:0] pinctl_r; // applied pin control
  logic [7:0] hi_byte_r; // high byte waiting for its write
  logic [9:0] hi_addr_r; // its register address
  logic reload_pulse; // software restart
  logic cs_lvl, rd_lvl, wr_lvl; // filtered pin levels
  // word target decode
  logic tgt_en;
  logic [9:0] tgt_lo;
  logic [9:0] tgt_hi;
  // store access
  logic ram_we;
  logic [9:0] ram_waddr;
  logic [7:0] ram_wdata;
  logic [6:0] widx_dec;
  logic [6:0] ridx_dec;
  logic [7:0] ram_rdata;
  logic loading;
  logic [7:0] rd_nxt;
  logic want_lvl;

  generate
    if (EE_AW < 6)
    begin : g_chk
      $error("eecfg_loader: word address needs 6 bits");
    end
  endgenerate

  // byte store index of a register address; bit 6 marks a hit
  function automatic logic [6:0] idx_of(input logic [9:0] a);
    logic [6:0] pb;
    logic [6:0] r;
    pb = 7'h00;
    r = 7'h00;
    if (a[9:8] == `EECFG_PORT1)
      pb = 7'h06;
    else if (a[9:8] == `EECFG_PORT3)
      pb = 7'h0C;
    if (a[9:8] != `EECFG_PAGE_LD)
    begin
      case (a[7:0])
        `EECFG_R_PC61: r = 7'h44 + pb;
        `EECFG_R_PC66: r = 7'h45 + pb;
        `EECFG_R_PC67: r = 7'h46 + pb;
        `EECFG_R_PC6D: r = 7'h47 + pb;
        `EECFG_R_TAGL: r = 7'h48 + pb;
        `EECFG_R_TAGH: r = 7'h49 + pb;
        default: r = 7'h00;
      endcase
    end
    if (a[9:8] == `EECFG_PORT0)
    begin
      if (a[7:0] == `EECFG_R_SW52)
        r = 7'h40;
      else if (a[7:0] == `EECFG_R_SW53)
        r = 7'h41;
      else if (a[7:0] == `EECFG_R_SW58)
        r = 7'h42;
      else if (a[7:0] == `EECFG_R_SW59)
        r = 7'h43;
      else if (a[7:0] == `EECFG_R_VPRL)
        r = 7'h56;
      else if (a[7:0] == `EECFG_R_VPRH)
        r = 7'h57;
      else if (a[7:4] == `EECFG_R_VGRP_HI)
        r = 7'h58 + {3'h0, a[3:0]};
      else if (a[7:4] == `EECFG_R_TOS_HI)
        r = 7'h68 + {3'h0, a[3:0]};
    end
    return r;
  endfunction

  // target registers and group gate of the current word
  always_comb
  begin
    tgt_en = 1'b0;
    tgt_lo = 10'h000;
    tgt_hi = 10'h000;
    case (word_r)
      6'h11, 6'h12:
      begin
        tgt_en = (grpctl_r[`EECFG_G_SW +: 2] == `EECFG_EN_VAL);
        tgt_lo = {`EECFG_PORT0, word_r[0] ? `EECFG_R_SW52 : `EECFG_R_SW58};
        tgt_hi = {`EECFG_PORT0, word_r[0] ? `EECFG_R_SW53 : `EECFG_R_SW59};
      end
      6'h13, 6'h14, 6'h15, 6'h16, 6'h19, 6'h1A:
      begin
        tgt_en = (grpctl_r[`EECFG_G_PORT +: 2] == `EECFG_EN_VAL);
        tgt_lo[9:8] = (word_r < 6'h15) ? `EECFG_PORT0 :
                      (word_r < 6'h17) ? `EECFG_PORT1 : `EECFG_PORT3;
        tgt_hi[9:8] = tgt_lo[9:8];
        tgt_lo[7:0] = word_r[0] ? `EECFG_R_PC61 : `EECFG_R_PC67;
        tgt_hi[7:0] = word_r[0] ? `EECFG_R_PC66 : `EECFG_R_PC6D;
        if (word_r == 6'h19)
        begin
          tgt_lo[7:0] = `EECFG_R_PC61;
          tgt_hi[7:0] = `EECFG_R_PC66;
        end
        else if (word_r == 6'h1A)
        begin
          tgt_lo[7:0] = `EECFG_R_PC67;
          tgt_hi[7:0] = `EECFG_R_PC6D;
        end
      end
      6'h1B, 6'h1C, 6'h1E:
      begin
        tgt_en = (grpctl_r[`EECFG_G_TAG +: 2] == `EECFG_EN_VAL);
        tgt_lo = {(word_r == 6'h1B) ? `EECFG_PORT0 :
                  (word_r == 6'h1C) ? `EECFG_PORT1 : `EECFG_PORT3, `EECFG_R_TAGL};
        tgt_hi = {tgt_lo[9:8], `EECFG_R_TAGH};
      end
      6'h1F:
      begin
        tgt_en = (grpctl_r[`EECFG_G_VPRI +: 2] == `EECFG_EN_VAL);
        tgt_lo = {`EECFG_PORT0, `EECFG_R_VPRL};
        tgt_hi = {`EECFG_PORT0, `EECFG_R_VPRH};
      end
      6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27:
      begin
        tgt_en = (grpctl_r[`EECFG_G_VGRP +: 2] == `EECFG_EN_VAL);
        tgt_lo = {`EECFG_PORT0, `EECFG_R_VGRP_HI, word_r[2:0], 1'b0};
        tgt_hi = {`EECFG_PORT0, `EECFG_R_VGRP_HI, word_r[2:0], 1'b1};
      end
      6'h28, 6'h29, 6'h2A, 6'h2B, 6'h2C, 6'h2D, 6'h2E, 6'h2F:
      begin
        tgt_en = (grpctl_r[`EECFG_G_TOS +: 2] == `EECFG_EN_VAL);
        tgt_lo = {`EECFG_PORT0, `EECFG_R_TOS_HI, word_r[2:0], 1'b0};
        tgt_hi = {`EECFG_PORT0, `EECFG_R_TOS_HI, word_r[2:0], 1'b1};
      end
      default: tgt_en = 1'b0; // reserved and header words store nothing
    endcase
  end

  assign loading = (state_r != eecfg_pkg::S_DONE);
  assign o_ee_req = (state_r == eecfg_pkg::S_FETCH);
  assign o_ee_addr = EE_AW'(word_r);
  assign o_load_done = ~loading;
  assign reload_pulse = i_wr && ~loading && (i_addr == {`EECFG_PAGE_LD, `EECFG_L_CTRL}) && i_wdata[0];

  // fetch sequencer
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      state_r <= eecfg_pkg::S_FETCH;
      word_r <= `EECFG_W_MAC0;
    end
    else if (i_ce)
    begin
      case (state_r)
        eecfg_pkg::S_FETCH:
          if (i_ee_valid)
          begin
            if (tgt_en)
              state_r <= eecfg_pkg::S_HIGH; // high byte next cycle
            else if (word_r == `EECFG_W_LAST)
              state_r <= eecfg_pkg::S_DONE;
            else
              word_r <= word_r + 6'h01;
          end
        eecfg_pkg::S_HIGH:
          if (word_r == `EECFG_W_LAST)
            state_r <= eecfg_pkg::S_DONE;
          else
          begin
            word_r <= word_r + 6'h01;
            state_r <= eecfg_pkg::S_FETCH;
          end
        eecfg_pkg::S_DONE:
          if (reload_pulse)
          begin
            word_r <= `EECFG_W_MAC0;
            state_r <= eecfg_pkg::S_FETCH;
          end
        default: state_r <= eecfg_pkg::S_DONE;
      endcase
    end
  end

  // header words: address, ids, pin and phy control
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_mac_addr <= 48'h0000_0000_0000;
      o_vendor_id <= VENDOR_ID_DEF;
      o_product_id <= PRODUCT_ID_DEF;
      autold_r <= 16'h0000;
      grpctl_r <= 16'h0000;
      pinctl_r <= `EECFG_PIN_RST;
      o_mdix_p0 <= `EECFG_MDIX_RST;
      o_mdix_p1 <= `EECFG_MDIX_RST;
    end
    else if (i_ce && i_ee_valid && (state_r == eecfg_pkg::S_FETCH))
    begin
      case (word_r)
        `EECFG_W_MAC0: o_mac_addr[15:0] <= i_ee_data;
        `EECFG_W_MAC1: o_mac_addr[31:16] <= i_ee_data;
        `EECFG_W_MAC2: o_mac_addr[47:32] <= i_ee_data;
        `EECFG_W_AUTOLD: autold_r <= i_ee_data;
        `EECFG_W_VID:
          if (autold_r[`EECFG_AL_ID +: 2] == `EECFG_EN_VAL)
            o_vendor_id <= i_ee_data;
        `EECFG_W_PID:
          if (autold_r[`EECFG_AL_ID +: 2] == `EECFG_EN_VAL)
            o_product_id <= i_ee_data;
        `EECFG_W_PINCTL:
          if (autold_r[`EECFG_AL_PIN +: 2] == `EECFG_EN_VAL)
            pinctl_r <= i_ee_data[`EECFG_PIN_W-1:0];
        `EECFG_W_PHYCTL:
          if (autold_r[`EECFG_AL_PHY +: 2] == `EECFG_EN_VAL)
          begin
            o_mdix_p0 <= i_ee_data[`EECFG_PHY_MDIX0];
            o_mdix_p1 <= i_ee_data[`EECFG_PHY_MDIX1];
          end
        `EECFG_W_GRPCTL: grpctl_r <= i_ee_data;
        default: grpctl_r <= grpctl_r;
      endcase
    end
  end

  // park the high byte for the following cycle
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      hi_byte_r <= 8'h00;
      hi_addr_r <= 10'h000;
    end
    else if (i_ce && i_ee_valid && (state_r == eecfg_pkg::S_FETCH))
    begin
      hi_byte_r <= i_ee_data[15:8];
      hi_addr_r <= tgt_hi;
    end
  end

  // store write mux: loader while busy, software only once done
  always_comb
  begin
    ram_we = 1'b0;
    ram_waddr = i_addr;
    ram_wdata = i_wdata;
    if (state_r == eecfg_pkg::S_FETCH)
    begin
      ram_we = i_ee_valid && tgt_en; // low byte
      ram_waddr = tgt_lo;
      ram_wdata = i_ee_data[7:0];
    end
    else if (state_r == eecfg_pkg::S_HIGH)
    begin
      ram_we = 1'b1; // high byte to its partner register
      ram_waddr = hi_addr_r;
      ram_wdata = hi_byte_r;
    end
    else
      ram_we = i_wr && (ram_waddr[9:8] != `EECFG_PAGE_LD);
  end

  assign widx_dec = idx_of(ram_waddr);
  assign ridx_dec = idx_of(i_addr);

  eecfg_cfg_ram #(
    .NBYTES(`EECFG_NBYTES),
    .IW(6)
  ) u_ram (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_we(ram_we && widx_dec[6]),
    .i_widx(widx_dec[5:0]),
    .i_wdata(ram_wdata),
    .i_ridx(ridx_dec[5:0]),
    .o_rdata(ram_rdata)
  );

  // read data select
  always_comb
  begin
    rd_nxt = 8'h00;
    if (i_addr[9:8] == `EECFG_PAGE_LD)
    begin
      case (i_addr[7:0])
        `EECFG_L_VIDL: rd_nxt = o_vendor_id[7:0];
        `EECFG_L_VIDH: rd_nxt = o_vendor_id[15:8];
        `EECFG_L_PIDL: rd_nxt = o_product_id[7:0];
        `EECFG_L_PIDH: rd_nxt = o_product_id[15:8];
        `EECFG_L_PIN: rd_nxt = {3'h0, pinctl_r};
        `EECFG_L_PHY: rd_nxt = {6'h00, o_mdix_p0, o_mdix_p1};
        `EECFG_L_STAT: rd_nxt = {6'h00, loading, ~loading};
        default:
          if (i_addr[7:0] < `EECFG_L_VIDL)
            rd_nxt = o_mac_addr[{i_addr[2:0], 3'h0} +: 8];
      endcase
    end
    else if (~loading && ridx_dec[6])
      rd_nxt = ram_rdata; // hidden until loading ends
  end

  // read data one cycle after the strobe
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_rdata <= 8'h00;
    else if (i_ce && i_rd)
      o_rdata <= rd_nxt;
  end

  eecfg_pin_sync #(.RST_VAL(1'b1)) u_cs (
    .i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_pin(i_cs_pin), .o_level(cs_lvl)
  );
  eecfg_pin_sync #(.RST_VAL(1'b1)) u_rd (
    .i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_pin(i_read_strobe_in), .o_level(rd_lvl)
  );
  eecfg_pin_sync #(.RST_VAL(1'b1)) u_wr (
    .i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_pin(i_write_strobe_in), .o_level(wr_lvl)
  );

  // strobe polarity: clear bit means active low
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_cs_act <= 1'b0;
      o_rd_act <= 1'b0;
      o_wr_act <= 1'b0;
    end
    else if (i_ce)
    begin
      o_cs_act <= ~(cs_lvl ^ pinctl_r[`EECFG_PIN_CS]);
      o_rd_act <= ~(rd_lvl ^ pinctl_r[`EECFG_PIN_RD]);
      o_wr_act <= ~(wr_lvl ^ pinctl_r[`EECFG_PIN_WR]);
    end
  end

  assign want_lvl = i_irq_req ^ pinctl_r[`EECFG_PIN_IRQLOW];

  // interrupt pin level and drive type
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_irq_out <= 1'b0;
      o_irq_oe <= 1'b1;
    end
    else if (i_ce)
    begin
      if (pinctl_r[`EECFG_PIN_IRQOC])
      begin
        o_irq_out <= 1'b0; // pull low only, release otherwise
        o_irq_oe <= ~want_lvl;
      end
      else
      begin
        o_irq_out <= want_lvl;
        o_irq_oe <= 1'b1;
      end
    end
  end
endmodule

// ### sim/eecfg_ee_model.sv
// Purpose: configuration word store that answers the loader's fetches
// Assumes: same clock as the loader, one request open at a time
// Notes: bench fills mem; i_dly sets the answer delay in cycles
`timescale 1ns/1ps
module eecfg_ee_model (
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic [5:0] i_addr,
  input wire logic [3:0] i_dly,
  output logic o_valid = 1'b0,
  output logic [15:0] o_data = 16'h0000
);
  logic [15:0] mem [48]; // image, reserved fields kept zero by the bench
  logic [3:0] wait_r = 4'h0; // cycles waited on the open request
  // one-cycle answer after i_dly cycles, data scrambled otherwise
  always @(posedge i_clk)
  begin
    if (o_valid || !i_req)
    begin
      o_valid <= 1'b0;
      wait_r <= 4'h0;
      o_data <= ~o_data;
    end
    else if (wait_r == i_dly)
    begin
      o_valid <= 1'b1;
      o_data <= mem[i_addr];
    end
    else
    begin
      wait_r <= wait_r + 4'h1;
      o_data <= ~o_data;
    end
  end
endmodule

// ### sim/eecfg_loader_sva.sv
// Purpose: port assertions for the configuration loader
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every loader instance
`timescale 1ns/1ps
module eecfg_loader_sva #(
  parameter int EE_AW = 6
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic o_ee_req,
  input wire logic [EE_AW-1:0] o_ee_addr,
  input wire logic i_ee_valid,
  input wire logic [15:0] i_ee_data,
  input wire logic [9:0] i_addr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [47:0] o_mac_addr,
  input wire logic o_mdix_p0,
  input wire logic o_mdix_p1,
  input wire logic o_load_done
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  logic take; // word accepted at this edge
  assign take = i_ce && o_ee_req && i_ee_valid;
  req_hold_a: assert property (o_ee_req && !i_ee_valid |=> o_ee_req && $stable(o_ee_addr))
    else $error("fetch moved before its answer");
  // a restart from the done state may move the fetch back to word zero
  addr_step_a: assert property ($changed(o_ee_addr) |->
    (o_ee_addr - $past(o_ee_addr) == EE_AW'(1)) || ($past(o_load_done) && o_ee_addr == '0))
    else $error("word fetch out of order");
  // the last stored word ends in done, checked by done_end_a
  gap_one_a: assert property ($fell(o_ee_req) && !o_load_done && o_ee_addr != EE_AW'(6'h2F) |=> o_ee_req)
    else $error("high byte pause not one cycle");
  rsvd_skip_a: assert property (take && (o_ee_addr inside {[8:15], 23, 24, 29}) |=> o_ee_req)
    else $error("reserved word treated as stored");
  done_end_a: assert property (take && o_ee_addr == EE_AW'(6'h2F) |-> ##[1:2] o_load_done)
    else $error("load not done after last word");
  done_idle_a: assert property (o_load_done |-> !o_ee_req)
    else $error("fetch while done");
  mac_cap_a: assert property (take && o_ee_addr == '0 |=> o_mac_addr[15:0] == $past(i_ee_data))
    else $error("station address low word wrong");
  mdix_rst_a: assert property ($past(i_srst) |-> o_mdix_p0 && o_mdix_p1)
    else $error("crossover default not on");
  early_rd_a: assert property (i_rd && !o_load_done && i_addr[9:8] != 2'h2 |=> o_rdata == 8'h00)
    else $error("register readable during load");
endmodule
bind eecfg_loader eecfg_loader_sva #(.EE_AW(EE_AW)) u_sva (.i_clk, .i_srst, .i_ce, .o_ee_req,
  .o_ee_addr, .i_ee_valid, .i_ee_data, .i_addr, .i_rd, .o_rdata, .o_mac_addr, .o_mdix_p0,
  .o_mdix_p1, .o_load_done);

// ### sim/eecfg_loader_test.sv
// Purpose: self-checking bench of the configuration loader
// Assumes: word store model on the fetch side
// Notes: three images cover enabled and disabled groups
`timescale 1ns/1ps
module eecfg_loader_test;
  localparam logic [15:0] VID_DEF = 16'hA5C3; // arbitrary value
  localparam logic [15:0] PID_DEF = 16'h3C5A; // arbitrary value
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_ce = 1'b1; // held high throughout
  logic i_wr = 1'b0, i_rd = 1'b0, o_ee_req, i_ee_valid;
  logic [5:0] o_ee_addr;
  logic [15:0] i_ee_data, o_vendor_id, o_product_id;
  logic [9:0] i_addr = 10'h000;
  logic [7:0] i_wdata = 8'h00, o_rdata;
  logic i_cs_pin = 1'b1, i_read_strobe_in = 1'b1, i_write_strobe_in = 1'b1, i_irq_req = 1'b0;
  logic o_cs_act, o_rd_act, o_wr_act, o_irq_out, o_irq_oe, o_mdix_p0, o_mdix_p1, o_load_done;
  logic [47:0] o_mac_addr;
  logic [3:0] dly = 4'h0; // answer delay of the word store
  logic [15:0] img [48]; // current image
  int error_cnt = 0;
  int compares = 0;
  // 10 MHz clock
  initial
  begin
    forever #50 i_clk = ~i_clk;
  end
  eecfg_loader #(.VENDOR_ID_DEF(VID_DEF), .PRODUCT_ID_DEF(PID_DEF)) dut (.i_clk, .i_srst, .i_ce,
    .o_ee_req, .o_ee_addr, .i_ee_valid, .i_ee_data, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_cs_pin, .i_read_strobe_in, .i_write_strobe_in, .o_cs_act, .o_rd_act, .o_wr_act, .i_irq_req,
    .o_irq_out, .o_irq_oe, .o_mac_addr, .o_vendor_id, .o_product_id, .o_mdix_p0, .o_mdix_p1,
    .o_load_done);
  eecfg_ee_model ee (.i_clk, .i_req(o_ee_req), .i_addr(o_ee_addr), .i_dly(dly),
    .o_valid(i_ee_valid), .o_data(i_ee_data));
  // verdict and end of run
  task automatic complete_run();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // one-cycle read, data judged in the next cycle
  task automatic rchk(input logic [9:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk({8'h00, o_rdata}, {8'h00, exp});
  endtask
  // image setup, reset, bounded wait for done
  task automatic load(input logic [15:0] w3, w6, w7, w16, input logic [3:0] d);
    for (int w = 0; w < 48; w++)
      img[w] = {w[7:0] ^ 8'h5A, w[7:0] + 8'h31};
    img[3] = w3; // reserved fields zero
    img[6] = w6;
    img[7] = w7; // bits 13:12 zero
    img[16] = w16; // bits 15:12 zero
    ee.mem = img;
    @(posedge i_clk);
    dly <= d;
    i_srst <= 1'b1;
    repeat (10) @(posedge i_clk);
    i_srst <= 1'b0;
    rchk(10'h052, 8'h00);
    rchk(10'h20C, 8'h02);
    wait_done();
    rchk(10'h20C, 8'h01);
  endtask
  // bounded wait for the end of a load, timeout goes to the verdict
  task automatic wait_done();
    for (int n = 0; n < 2000 && o_load_done !== 1'b1; n++)
      @(posedge i_clk);
    if (o_load_done !== 1'b1)
    begin
      error_cnt++;
      complete_run();
    end
  endtask
  // one word against its register pair
  task automatic cw(input int w, input logic [9:0] lo, hi, input logic [1:0] f);
    rchk(lo, f == 2'h1 ? img[w][7:0] : 8'h00);
    rchk(hi, f == 2'h1 ? img[w][15:8] : 8'h00);
  endtask
  // switch registers after load
  task automatic t_regs();
    logic [15:0] g;
    g = img[16];
    cw(17, 10'h052, 10'h053, g[1:0]);
    cw(18, 10'h058, 10'h059, g[1:0]);
    cw(19, 10'h061, 10'h066, g[3:2]);
    cw(20, 10'h067, 10'h06D, g[3:2]);
    cw(21, 10'h161, 10'h166, g[3:2]);
    cw(22, 10'h167, 10'h16D, g[3:2]);
    cw(25, 10'h361, 10'h366, g[3:2]);
    cw(26, 10'h367, 10'h36D, g[3:2]);
    cw(27, 10'h06E, 10'h06F, g[5:4]);
    cw(28, 10'h16E, 10'h16F, g[5:4]);
    cw(30, 10'h36E, 10'h36F, g[5:4]);
    cw(31, 10'h0D0, 10'h0D1, g[7:6]);
    for (int i = 0; i < 8; i++)
    begin
      cw(32 + i, 10'h0B0 + 10'(2 * i), 10'h0B1 + 10'(2 * i), g[9:8]);
      cw(40 + i, 10'h0C0 + 10'(2 * i), 10'h0C1 + 10'(2 * i), g[11:10]);
    end
  endtask
  // captured words, pin polarity and interrupt drive
  task automatic t_cfg();
    logic [15:0] vid, pid;
    logic [4:0] pin;
    logic lvl;
    for (int b = 0; b < 6; b++)
      rchk(10'h200 + 10'(b), img[b / 2][8 * (b % 2) +: 8]);
    for (int w = 0; w < 3; w++)
      chk(o_mac_addr[16 * w +: 16], img[w]);
    vid = img[3][1:0] == 2'h1 ? img[4] : VID_DEF;
    pid = img[3][1:0] == 2'h1 ? img[5] : PID_DEF;
    chk(o_vendor_id, vid);
    chk(o_product_id, pid);
    pin = img[3][3:2] == 2'h1 ? img[6][4:0] : 5'h00;
    rchk(10'h20A, {3'h0, pin});
    chk({14'h0, o_mdix_p0, o_mdix_p1}, img[3][15:14] == 2'h1 ? {14'h0, img[7][15:14]} : 16'h0003);
    for (int l = 0; l < 2; l++)
    begin
      @(posedge i_clk);
      i_cs_pin <= l[0];
      i_read_strobe_in <= l[0];
      i_write_strobe_in <= l[0];
      i_irq_req <= l[0];
      repeat (6) @(posedge i_clk);
      #1;
      chk({13'h0, o_cs_act, o_rd_act, o_wr_act}, {13'h0, {pin[0], pin[1], pin[2]} ~^ {3{l[0]}}});
      lvl = l[0] ^ pin[3];
      chk({14'h0, o_irq_out, o_irq_oe}, pin[4] ? {14'h0, 1'b0, ~lvl} : {14'h0, lvl, 1'b1});
    end
  endtask
  // writes after load: config, read-only and unmapped places, then a software restart
  task automatic t_wr();
    wr(10'h052, 8'hA5);
    rchk(10'h052, 8'hA5);
    wr(10'h200, 8'hFF);
    rchk(10'h200, img[0][7:0]);
    wr(10'h0FF, 8'h3C);
    rchk(10'h0FF, 8'h00);
    wr(10'h20D, 8'h01);
    rchk(10'h20C, 8'h02);
    rchk(10'h052, 8'h00);
    wait_done();
    rchk(10'h20C, 8'h01);
    rchk(10'h052, img[17][7:0]);
    rchk(10'h20D, 8'h00);
  endtask
  // main sequence
  initial
  begin
    load(16'h4005, 16'h001F, 16'h4000, 16'h0555, 4'h0);
    t_regs();
    t_cfg();
    t_wr();
    load(16'hC00E, 16'h001F, 16'h4000, 16'h0E38, 4'h3);
    t_regs();
    t_cfg();
    load(16'h4004, 16'h0005, 16'h8000, 16'h0141, 4'h1);
    t_regs();
    t_cfg();
    complete_run();
  end
endmodule
